// >>> hdl/tick_timer_and_tone_divider.v
// tick interrupt timer and tone divider output with avalon register slave
`timescale 1ns/1ps
`default_nettype none
`include "tick_tone_map.vh"

// Summary of operation
// RULE_01: periodic tick request while tick enabled
// RULE_02: fast modes, main clock tick rates
// RULE_03: fast modes, sub clock tick rates
// RULE_04: slow modes allow only codes 000, 001
// RULE_05: software changes tick rate only while disabled
// RULE_06: rate and enable in one write
// RULE_07: first tick on first tap falling edge
// RULE_08: enabling never clears the shared divider
// RULE_09: tone pin carries half duty square wave
// RULE_10: control bit 7 gates tone output
// RULE_11: tone rates from main or sub clock
// RULE_12: software changes tone rate only while disabled
// RULE_13: control register field layout
// RULE_14: control register resets to zero
// RULE_15: main and sub clock share one chain
// RULE_16: one-cycle tick pulse, tone rests inactive
// RULE_17: taps sampled and edge-detected on system clock
module tick_timer_and_tone_divider (
  input wire ref_clk,
  input wire rst,
  input wire [`ADDR_W-1:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [`DATA_W-1:0] avsWritedata,
  input wire [3:0] avsByteenable,
  output reg [`DATA_W-1:0] avsReaddata,
  output wire avsWaitrequest,
  input wire subClkPin,
  input wire slowMode,
  output reg tickIrq,
  output reg toneOutN,
  output wire irq
);

  // functions

  // byte address of a register from its index
  function [`ADDR_W-1:0] regAddr;
    input [7:0] idx;
    begin
      regAddr = {idx, 2'b00};
    end
  endfunction

  // tick rate code to upper chain bit
  function [`TAP_W-1:0] tickTap;
    input [2:0] code;
    begin
      case (code)
        3'h0: tickTap = `TICK_TAP_0;
        3'h1: tickTap = `TICK_TAP_1;
        3'h2: tickTap = `TICK_TAP_2;
        3'h3: tickTap = `TICK_TAP_3;
        3'h4: tickTap = `TICK_TAP_4;
        3'h5: tickTap = `TICK_TAP_5;
        3'h6: tickTap = `TICK_TAP_6;
        default: tickTap = `TICK_TAP_7;
      endcase
    end
  endfunction

  // tone rate code to upper chain bit
  function [`TAP_W-1:0] toneTap;
    input [1:0] code;
    begin
      case (code)
        2'h0: toneTap = `TONE_TAP_0;
        2'h1: toneTap = `TONE_TAP_1;
        2'h2: toneTap = `TONE_TAP_2;
        default: toneTap = `TONE_TAP_3;
      endcase
    end
  endfunction

  // count a settle timer down to zero
  function [1:0] holdStep;
    input [1:0] count;
    begin
      holdStep = (count == 2'h0) ? 2'h0 : count - 2'h1;
    end
  endfunction

  // registers and wires

  reg [`REG_W-1:0] control_q;
  reg [`ST_W-1:0] status_q;
  reg [`ST_W-1:0] status_d;
  reg [`ST_W-1:0] mask_q;
  reg ack_q;
  reg [`LOW_W-1:0] lowDiv_q;
  reg [`UP_W-1:0] upDiv_q;
  reg tickIrq_d;
  reg toneOutN_d;
  reg [`DATA_W-1:0] readValue;
  reg [1:0] tickHold_q;
  reg [1:0] toneHold_q;

  wire busReq;
  wire busAccept;
  wire wrAccept;
  wire hitControl;
  wire hitStatus;
  wire hitMask;
  wire laneLow;

  wire toneEnable;
  wire [1:0] toneRate;
  wire slowSource;
  wire tickEnable;
  wire [2:0] tickRate;

  wire useSub;
  wire lowCarry;
  wire upStep;
  wire subRise;
  wire tickTapRaw;
  wire toneTapRaw;
  wire tickTapFall;
  wire toneTapLevel;
  wire slowCodeBad;
  wire tickFire;
  wire tickRateWrite;
  wire toneRateWrite;

  // control fields

  assign toneEnable = control_q[`CTL_TONE_EN]; // [RULE_13]
  assign toneRate = control_q[`CTL_TONE_RATE_HI:`CTL_TONE_RATE_LO]; // [RULE_13]
  assign slowSource = control_q[`CTL_SLOW_SRC]; // [RULE_13]
  assign tickEnable = control_q[`CTL_TICK_EN]; // [RULE_13]
  assign tickRate = control_q[`CTL_TICK_RATE_HI:`CTL_TICK_RATE_LO]; // [RULE_13]

  // avalon slave: one wait state, then the access completes

  assign busReq = avsRead | avsWrite;
  assign avsWaitrequest = busReq & ~ack_q;
  assign busAccept = busReq & ack_q;
  assign wrAccept = avsWrite & ack_q & laneLow;
  assign laneLow = avsByteenable[0];
  assign hitControl = (avsAddress == regAddr(`IDX_CONTROL));
  assign hitStatus = (avsAddress == regAddr(`IDX_STATUS));
  assign hitMask = (avsAddress == regAddr(`IDX_MASK));

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= busReq & ~ack_q;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    readValue = {`DATA_W{1'b0}};
    if (hitControl) begin
      readValue[`REG_W-1:0] = control_q;
    end else if (hitStatus) begin
      readValue[`ST_W-1:0] = status_q;
    end else if (hitMask) begin
      readValue[`ST_W-1:0] = mask_q;
    end
  end

  // read data captured in the wait cycle, stands at the accepting edge
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avsReaddata <= {`DATA_W{1'b0}};
    end else if (avsRead & ~ack_q) begin
      avsReaddata <= readValue;
    end
  end

  // control and mask registers

  // rate and enable may land in the same write
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control_q <= `CTL_RESET; // [RULE_14]
    end else if (wrAccept & hitControl) begin
      control_q <= avsWritedata[`REG_W-1:0]; // [RULE_06]
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_q <= `MASK_RESET;
    end else if (wrAccept & hitMask) begin
      mask_q <= avsWritedata[`ST_W-1:0];
    end
  end

  // shared divider chain

  // sub clock pin passes two flops before use
  tap_edge_sampler subSampler (
    .ref_clk(ref_clk),
    .rst(rst),
    .sampleIn(subClkPin),
    .level(),
    .rise(subRise),
    .fall()
  );

  // upper chain runs from sub clock when selected or in slow modes
  assign useSub = slowSource | slowMode; // [RULE_15]
  assign lowCarry = ~slowMode & (&lowDiv_q);
  assign upStep = useSub ? subRise : lowCarry; // [RULE_15]

  // main clock stops in slow modes, so the low stage holds
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowDiv_q <= `LOW_RESET;
    end else if (~slowMode) begin
      lowDiv_q <= lowDiv_q + 1'b1;
    end
  end

  // never cleared by software, enable or rate change
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upDiv_q <= `UP_RESET; // [RULE_08]
    end else if (upStep) begin
      upDiv_q <= upDiv_q + 1'b1; // [RULE_15]
    end
  end

  // tap selection and sampling

  // same chain bit serves main and sub clock rates
  assign tickTapRaw = upDiv_q[tickTap(tickRate)]; // [RULE_02] [RULE_03]
  assign toneTapRaw = upDiv_q[toneTap(toneRate)]; // [RULE_11]

  tap_edge_sampler tickSampler (
    .ref_clk(ref_clk),
    .rst(rst),
    .sampleIn(tickTapRaw),
    .level(),
    .rise(),
    .fall(tickTapFall)
  ); // [RULE_17]

  tap_edge_sampler toneSampler (
    .ref_clk(ref_clk),
    .rst(rst),
    .sampleIn(toneTapRaw),
    .level(toneTapLevel),
    .rise(),
    .fall()
  ); // [RULE_17]

  // settle timers: a rate change swaps the tap under its sampler, and the
  // stale sample would show as a false edge or a short tone pulse

  assign tickRateWrite = wrAccept & hitControl &
    (avsWritedata[`CTL_TICK_RATE_HI:`CTL_TICK_RATE_LO] != tickRate);
  assign toneRateWrite = wrAccept & hitControl &
    (avsWritedata[`CTL_TONE_RATE_HI:`CTL_TONE_RATE_LO] != toneRate);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickHold_q <= 2'h0;
    end else if (tickRateWrite) begin
      tickHold_q <= `TAP_SETTLE;
    end else begin
      tickHold_q <= holdStep(tickHold_q);
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      toneHold_q <= 2'h0;
    end else if (toneRateWrite) begin
      toneHold_q <= `TAP_SETTLE;
    end else begin
      toneHold_q <= holdStep(toneHold_q);
    end
  end

  // tick interrupt

  // codes above 001 give no tick in slow modes
  assign slowCodeBad = slowMode & (tickRate > `SLOW_MAX_CODE); // [RULE_04]

  // first falling edge after enable fires, not a full period later
  assign tickFire = tickEnable & tickTapFall & ~slowCodeBad & (tickHold_q == 2'h0); // [RULE_07]

  always @* begin
    tickIrq_d = tickFire; // [RULE_16]
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickIrq <= 1'b0;
    end else begin
      tickIrq <= tickIrq_d; // [RULE_16]
    end
  end

  // tone output, active low, rests high until the new tap has settled

  always @* begin
    if (toneEnable & (toneHold_q == 2'h0)) begin
      toneOutN_d = ~toneTapLevel; // [RULE_09] [RULE_10]
    end else begin
      toneOutN_d = 1'b1; // [RULE_16]
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      toneOutN <= 1'b1;
    end else begin
      toneOutN <= toneOutN_d;
    end
  end

  // sticky status, write one to clear, set wins

  always @* begin
    status_d = status_q;
    if (wrAccept & hitStatus) begin
      status_d = status_q & ~avsWritedata[`ST_W-1:0];
    end
    if (tickFire) begin
      status_d[`ST_TICK] = 1'b1; // [RULE_01]
    end
    if (tickEnable & slowCodeBad) begin
      status_d[`ST_RATE_FAULT] = 1'b1; // [RULE_04]
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_q <= `ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & mask_q);

endmodule // tick_timer_and_tone_divider

`default_nettype wire

// >>> shared/tick_tone_map.vh
// register map, field layout and divider taps of the tick timer and tone divider
`ifndef TICK_TONE_MAP_VH
`define TICK_TONE_MAP_VH

// register indices; byte address is four times the index
`define IDX_CONTROL 8'h36
`define IDX_STATUS 8'h37
`define IDX_MASK 8'h38
`define ADDR_W 10
`define DATA_W 32
`define REG_W 8

// control register fields
`define CTL_TONE_EN 7
`define CTL_TONE_RATE_HI 6
`define CTL_TONE_RATE_LO 5
`define CTL_SLOW_SRC 4
`define CTL_TICK_EN 3
`define CTL_TICK_RATE_HI 2
`define CTL_TICK_RATE_LO 0
`define CTL_RESET 8'h00

// status and mask fields
`define ST_TICK 0
`define ST_RATE_FAULT 1
`define ST_W 2
`define ST_RESET 2'h0
`define MASK_RESET 2'h0

// divider chain: low stage of main clock, upper stage shared with sub clock
`define LOW_W 8
`define LOW_RESET 8'h00
`define UP_W 15
`define UP_RESET 15'h0000
`define TAP_W 4

// upper-chain bit for each tick rate code (same bit for both sources)
`define TICK_TAP_0 4'hE
`define TICK_TAP_1 4'hC
`define TICK_TAP_2 4'h7
`define TICK_TAP_3 4'h5
`define TICK_TAP_4 4'h4
`define TICK_TAP_5 4'h3
`define TICK_TAP_6 4'h2
`define TICK_TAP_7 4'h0

// upper-chain bit for each tone rate code
`define TONE_TAP_0 4'h4
`define TONE_TAP_1 4'h3
`define TONE_TAP_2 4'h2
`define TONE_TAP_3 4'h1

// highest tick rate code valid in slow modes
`define SLOW_MAX_CODE 3'h1

// cycles a tap is ignored after its rate field changes (sampler depth plus one)
`define TAP_SETTLE 2'h3

`endif

// >>> hdl/tap_edge_sampler.v
// two-flop sampler with level and edge pulses for one divider tap or pin
`timescale 1ns/1ps
`default_nettype none

module tap_edge_sampler (
  input wire ref_clk,
  input wire rst,
  input wire sampleIn,
  output wire level,
  output wire rise,
  output wire fall
);

  reg stage1_q;
  reg stage2_q;
  reg prev_q;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      stage1_q <= sampleIn;
      stage2_q <= stage1_q;
      prev_q <= stage2_q;
    end
  end

  assign level = stage2_q;
  assign rise = stage2_q & ~prev_q;
  assign fall = prev_q & ~stage2_q;

endmodule // tap_edge_sampler

`default_nettype wire

// >>> bench/tick_tone_chk_sva.sv
// port assertions for the tick timer and tone divider
`timescale 1ns/1ps
`default_nettype none
module tick_tone_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic tickIrq,
  input wire logic toneOutN,
  input wire logic irq
);
  logic wrSeen_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence ackSeq;
    avsWaitrequest ##1 !avsWaitrequest;
  endsequence
  always @(posedge ref_clk or posedge rst) begin
    if (rst) wrSeen_q <= 1'h0;
    else if (avsWrite) wrSeen_q <= 1'h1;
  end
  chk_bus_ack: assert property ($rose(avsRead || avsWrite) |-> ackSeq)
    else $error("late bus answer");
  chk_read_upper: assert property (avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0)
    else $error("read upper bits set");
  chk_reset_quiet: assert property (!wrSeen_q |-> !tickIrq && toneOutN && !irq)
    else $error("active before setup");
  chk_tick_single: assert property (tickIrq |=> !tickIrq)
    else $error("tick pulse too long");
  chk_tick_spacing: assert property (tickIrq ##1 !tickIrq |=> !tickIrq [*8])
    else $error("ticks too close");
  chk_irq_cause: assert property ($rose(irq) |-> tickIrq || $past(avsWrite) || $past(avsWrite, 2))
    else $error("irq rose without cause");
  chk_irq_sticky: assert property ($fell(irq) |-> $past(avsWrite) || $past(avsWrite, 2))
    else $error("irq fell without write");
  chk_tone_steady: assert property ($changed(toneOutN) && !$past(avsWrite) && !$past(avsWrite, 2)
    |=> $stable(toneOutN) [*2])
    else $error("tone glitch");
endmodule // tick_tone_chk
bind tick_timer_and_tone_divider tick_tone_chk u_chk (.ref_clk, .rst, .avsRead, .avsWrite,
  .avsReaddata, .avsWaitrequest, .tickIrq, .toneOutN, .irq);
`default_nettype wire

// >>> bench/far_side_model.sv
// sub clock source and buzzer load on the tone pin
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter int HALF_NS = 453
) (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic toneOutN,
  output logic subClkPin,
  output int toneHalf
);
  int cnt = 0;
  logic last = 1'h1;
  initial subClkPin = 1'h0;
  // sub clock stands low while stopped
  always begin
    #(HALF_NS);
    subClkPin = run ? ~subClkPin : 1'h0;
  end
  // buzzer load measures each half period of the tone pin
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    if (toneOutN !== last) begin
      toneHalf <= cnt;
      cnt <= 1;
      last <= toneOutN;
    end
  end
endmodule // far_side_model
`default_nettype wire

// >>> bench/tick_timer_and_tone_divider_test.sv
// self-checking bench for the tick timer and tone divider
`timescale 1ns/1ps
`default_nettype none
module tick_timer_and_tone_divider_test;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic avsRead = 1'h0;
  logic avsWrite = 1'h0;
  logic slowMode = 1'h0;
  logic subRun = 1'h0;
  logic [9:0] avsAddress = 10'h000;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata, rd;
  logic avsWaitrequest, subClkPin, tickIrq, toneOutN, irq;
  int failures = 0, n_tests = 0, cyc = 0, seed = 13, subRises = 0, ticks = 0;
  int toneHalf, i, c0, c1, s0, s1;
  always #50 ref_clk = ~ref_clk;
  always @(posedge subClkPin) subRises++;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (tickIrq === 1'h1) ticks <= ticks + 1;
    if (cyc == 90000) begin
      failures++;
      end_sim();
    end
  end
  tick_timer_and_tone_divider u_dut (.ref_clk, .rst, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable(4'hF), .avsReaddata, .avsWaitrequest, .subClkPin,
    .slowMode, .tickIrq, .toneOutN, .irq);
  far_side_model #(.HALF_NS(453)) u_far (.ref_clk, .run(subRun), .toneOutN, .subClkPin,
    .toneHalf);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avsAddress <= {idx, 2'h0};
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avsWaitrequest !== 1'h0 && k < 20);
    rd = avsReaddata;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    if (k == 20) failures++;
    @(posedge ref_clk);
  endtask
  task automatic regChk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0);
    check(rd, exp);
  endtask
  task automatic waitTick(output int c, output int s);
    do @(posedge ref_clk); while (tickIrq !== 1'h1);
    c = cyc;
    s = subRises;
  endtask
  task automatic toneEdge;
    logic t;
    t = toneOutN;
    do @(posedge ref_clk); while (toneOutN === t);
  endtask
  function automatic int tickDiv(input int code, input logic sub);
    int e[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    return 1 << (sub ? e[code] - 8 : e[code]);
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    regChk(8'h36, 32'h0);
    regChk(8'h37, 32'h0);
    regChk(8'h38, 32'h0);
    bus(1'h1, 8'h3F, $random(seed));
    regChk(8'h3F, 32'h0);
    regChk(8'h36, 32'h0);
    bus(1'h1, 8'h38, 32'h3);
    $display("register test done");
    for (i = 5; i < 8; i++) begin
      bus(1'h1, 8'h36, 32'h8 | i);
      s0 = cyc;
      waitTick(c0, s1);
      check(c0 - s0 <= tickDiv(i, 1'h0) + 8, 32'h1);
      waitTick(c1, s1);
      check(c1 - c0, tickDiv(i, 1'h0));
      regChk(8'h36, 32'h8 | i);
      bus(1'h1, 8'h36, i);
    end
    check(irq, 32'h1);
    regChk(8'h37, 32'h1);
    bus(1'h1, 8'h38, 32'h2);
    check(irq, 32'h0);
    bus(1'h1, 8'h38, 32'h3);
    check(irq, 32'h1);
    bus(1'h1, 8'h37, 32'h1 | $random(seed));
    check(irq, 32'h0);
    $display("main clock tick test done");
    subRun <= 1'h1;
    for (i = 2; i < 8; i++) begin
      bus(1'h1, 8'h36, 32'h18 | i);
      waitTick(c0, s0);
      waitTick(c1, s1);
      check(s1 - s0, tickDiv(i, 1'h1));
      bus(1'h1, 8'h36, 32'h10 | i);
    end
    bus(1'h1, 8'h37, 32'h3);
    slowMode <= 1'h1;
    bus(1'h1, 8'h36, 32'hF);
    c0 = ticks;
    repeat (200) @(posedge ref_clk);
    check(ticks - c0, 32'h0);
    regChk(8'h37, 32'h2);
    bus(1'h1, 8'h36, 32'h7);
    for (i = 0; i < 2; i++) begin
      bus(1'h1, 8'h37, 32'h3);
      bus(1'h1, 8'h36, 32'h8 | i);
      regChk(8'h37, 32'h0);
      bus(1'h1, 8'h36, i);
    end
    $display("sub clock tick test done");
    slowMode <= 1'h0;
    subRun <= 1'h0;
    for (i = 0; i < 4; i++) begin
      bus(1'h1, 8'h36, 32'h80 | (i << 5));
      toneEdge();
      toneEdge();
      repeat (2) begin
        toneEdge();
        @(posedge ref_clk);
        check(toneHalf, 1 << (12 - i));
      end
      bus(1'h1, 8'h36, i << 5);
      repeat (2) @(posedge ref_clk);
      check(toneOutN, 32'h1);
    end
    $display("tone test done");
    end_sim();
  end
endmodule // tick_timer_and_tone_divider_test
`default_nettype wire
